// >>> shared/boot_consts.svh
// Constants for the serial memory boot loader.
// Assumes a 125 MHz core clock; included by its bare name.
`ifndef BOOT_CONSTS_SVH
`define BOOT_CONSTS_SVH

// Core clock period and least half period of the serial clock
`define CORE_CLK_NS    8
`define LINK_HALF_NS   40
`define LINK_HALF_CYC  ((`LINK_HALF_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)

// Fixed read opcode, start address, idle transmit byte
`define RD_OPCODE      8'h03
`define RD_ADDR        8'h00
`define IDLE_TX        8'h00

// Command byte classes and the control register write
`define WR_CLASS       2'h1
`define CTRL_WR_OP     8'h78
`define STOP_BIT_POS   8
`define LAST_VAL_IDX   2'h3

// Cycles the strap synchroniser needs before it is read
`define STRAP_SETTLE   2'h3

`endif

// >>> shared/boot_pkg.sv
// Types shared by the boot loader and its testbench.
// Uses nothing from the constants header.
`default_nettype none
package boot_pkg;

  // One executed boot command
  typedef struct packed {
    logic        is_write; // Register write with value
    logic [7:0]  op;       // Command byte
    logic [23:0] value;    // Three value bytes, first one high
  } boot_cmd_t;

  // Serial port pins driven by the device
  typedef struct packed {
    logic cs_n;      // Chip select level
    logic cs_oe_n;   // Chip select enable, low drives
    logic sclk;      // Serial clock level
    logic sclk_oe_n; // Serial clock enable, low drives
    logic sdo;       // Serial data out
  } link_out_t;

  // Loader sequence
  typedef enum logic [2:0] {
    S_SETTLE, S_OPC, S_ADR, S_FETCH, S_DONE, S_HOST
  } boot_state_t;

endpackage
`default_nettype wire

// >>> design/boot_byte_shift.sv
// Byte shifter for the boot link: makes the serial clock and moves
// one byte each way. Assumes sdi_s is already synchronised.
`timescale 1ns/10ps
`default_nettype none
`include "boot_consts.svh"

module boot_byte_shift (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,   // Load tx_byte and begin
  input  wire logic [7:0] tx_byte, // Byte to send, msb first
  input  wire logic       sdi_s,   // Synchronised serial input
  output logic            sclk,    // Serial clock level
  output logic            sdo,     // Serial data out
  output logic            done,    // One-cycle pulse, byte complete
  output logic [7:0]      rx_byte  // Byte received
);

  localparam logic [2:0] HALF = 3'(`LINK_HALF_CYC);

  logic       busy_reg, busy_next;   // Byte in progress
  logic [2:0] half_reg, half_next;   // Cycles within half period
  logic [2:0] bit_reg, bit_next;     // Bit index
  logic [7:0] tx_reg, tx_next;       // Outgoing shift register
  logic [7:0] rx_reg, rx_next;       // Incoming shift register
  logic       sclk_reg, sclk_next;   // Clock level
  logic       done_reg, done_next;   // Completion pulse

  // Next state of the shifter
  always_comb begin
    busy_next = busy_reg;
    half_next = half_reg;
    bit_next  = bit_reg;
    tx_next   = tx_reg;
    rx_next   = rx_reg;
    sclk_next = sclk_reg;
    done_next = 1'b0;
    if (start && !busy_reg) begin
      // Data leads the first rising edge by a half period
      busy_next = 1'b1;
      half_next = 3'h0;
      bit_next  = 3'h0;
      tx_next   = tx_byte;
      sclk_next = 1'b0;
    end else if (busy_reg) begin
      if (half_reg == HALF - 3'h1) begin
        half_next = 3'h0;
        sclk_next = !sclk_reg;
        if (sclk_reg) begin
          // End of high phase: input stable since the last fall
          rx_next = {rx_reg[6:0], sdi_s};
          if (bit_reg == 3'h7) begin
            busy_next = 1'b0;
            done_next = 1'b1;
          end else begin
            bit_next = bit_reg + 3'h1;
            tx_next  = {tx_reg[6:0], 1'b0};
          end
        end
      end else begin
        half_next = half_reg + 3'h1;
      end
    end
  end

  // Register the shifter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      half_reg <= 3'h0;
      bit_reg  <= 3'h0;
      tx_reg   <= 8'h00;
      rx_reg   <= 8'h00;
      sclk_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      half_reg <= half_next;
      bit_reg  <= bit_next;
      tx_reg   <= tx_next;
      rx_reg   <= rx_next;
      sclk_reg <= sclk_next;
      done_reg <= done_next;
    end
  end

  assign sclk    = sclk_reg;
  assign sdo     = tx_reg[7];
  assign done    = done_reg;
  assign rx_byte = rx_reg;

endmodule
`default_nettype wire

// >>> design/serial_eeprom_autoboot_loader.sv
// Boot loader: reads a command script from a serial memory at start-up
// and hands each command to the device's command executor.
// Assumes a 125 MHz clock and pins arriving unsynchronised.
`timescale 1ns/10ps
`default_nettype none
`include "boot_consts.svh"

// Overview of operation
// (R1) Strap high selects boot from serial memory
// (R2) Boot drives chip select and clock
// (R3) Chip select low, own clock, data out
// (R4) First send read opcode 03 hex
// (R5) Sample script bytes from serial input
// (R6) Apply each register write as loaded
// (R7) Any command runs as from host
// (R8) Write is command byte plus three bytes
// (R9) Stop bit in control write ends boot
// (R10) Afterwards release chip select and clock
module serial_eeprom_autoboot_loader
(
  input  wire logic          clk,        // Core clock
  input  wire logic          rstn,       // Synchronous reset, low
  input  wire logic          boot_strap, // Boot select strap pin
  input  wire logic          cs_n_in,    // Chip select pin level
  input  wire logic          sclk_in,    // Serial clock pin level
  input  wire logic          sdi,        // Serial data in pin
  output boot_pkg::link_out_t link_o,    // Driven pin levels, enables
  output boot_pkg::boot_cmd_t cmd,       // Command to execute
  output logic               cmd_valid,  // One-cycle command strobe
  output logic               boot_busy,  // Boot fetch running
  output logic               boot_done,  // Boot fetch ended by stop
  output logic               host_cs_n,  // Synchronised host select
  output logic               host_sclk   // Synchronised host clock
);
  import boot_pkg::*;

  // Two-stage synchronisers for pin inputs
  logic [1:0] strap_sync, sdi_sync, cs_sync, sclk_sync;

  boot_state_t state_reg, state_next;  // Loader sequence
  logic [1:0]  settle_reg, settle_next; // Strap settle count
  logic        start_reg, start_next;  // Byte launch pulse
  logic [7:0]  tx_reg, tx_next;        // Byte to launch
  logic [1:0]  idx_reg, idx_next;      // Byte index within command
  boot_cmd_t   asm_reg, asm_next;      // Command being assembled
  boot_cmd_t   cmd_reg, cmd_next;      // Issued command
  logic        valid_reg, valid_next;  // Issue strobe
  logic        cs_reg, cs_next;        // Chip select level
  logic        own_reg, own_next;      // Device owns the port
  logic        done_reg, done_next;    // Fetch ended by stop write
  logic        oe_n_reg, oe_n_next;    // Pin enables, low drives

  logic        sh_done;                // Byte complete
  logic [7:0]  sh_rx;                  // Received byte
  logic        sh_sclk;                // Generated clock
  logic        sh_sdo;                 // Outgoing data bit
  logic [23:0] val_new;                // Value with new byte

  // Pins first pass two flops, nothing reads stage zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_sync <= 2'h0;
      sdi_sync   <= 2'h0;
      cs_sync    <= 2'h3;
      sclk_sync  <= 2'h0;
    end else begin
      strap_sync <= {strap_sync[0], boot_strap};
      sdi_sync   <= {sdi_sync[0], sdi};
      cs_sync    <= {cs_sync[0], cs_n_in};
      sclk_sync  <= {sclk_sync[0], sclk_in};
    end
  end

  // Byte shifter making the serial clock
  boot_byte_shift u_shift (
    .clk     (clk),
    .rstn    (rstn),
    .start   (start_reg),
    .tx_byte (tx_reg),
    .sdi_s   (sdi_sync[1]),
    .sclk    (sh_sclk),
    .sdo     (sh_sdo),
    .done    (sh_done),
    .rx_byte (sh_rx)
  );

  assign val_new = {asm_reg.value[15:0], sh_rx};

  // Next state of the loader
  always_comb begin
    state_next  = state_reg;
    settle_next = settle_reg;
    start_next  = 1'b0;
    tx_next     = tx_reg;
    idx_next    = idx_reg;
    asm_next    = asm_reg;
    cmd_next    = cmd_reg;
    valid_next  = 1'b0;
    cs_next     = cs_reg;
    own_next    = own_reg;
    done_next   = done_reg;
    case (state_reg)
      S_SETTLE: begin
        // Wait for the strap synchroniser, then decide once
        if (settle_reg != `STRAP_SETTLE) begin
          settle_next = settle_reg + 2'h1;
        end else if (strap_sync[1]) begin
          state_next = S_OPC;                     // see (R1)
          cs_next    = 1'b0;                      // see (R3)
          own_next   = 1'b1;                      // see (R2)
          start_next = 1'b1;
          tx_next    = `RD_OPCODE;                // see (R4)
        end else begin
          state_next = S_HOST;
        end
      end
      S_OPC: begin
        // Opcode sent, follow with start address
        if (sh_done) begin
          state_next = S_ADR;
          start_next = 1'b1;
          tx_next    = `RD_ADDR;
        end
      end
      S_ADR: begin
        // Address sent, memory now streams its contents
        if (sh_done) begin
          state_next = S_FETCH;
          start_next = 1'b1;
          tx_next    = `IDLE_TX;
        end
      end
      S_FETCH: begin
        if (sh_done) begin
          start_next = 1'b1;
          if (idx_reg == 2'h0) begin
            asm_next.op       = sh_rx;            // see (R5)
            asm_next.value    = 24'h000000;
            asm_next.is_write = sh_rx[7:6] == `WR_CLASS;
            if (sh_rx[7:6] == `WR_CLASS) begin
              idx_next = 2'h1;                    // see (R8)
            end else begin
              // Other commands go out unchanged
              cmd_next.op       = sh_rx;          // see (R7)
              cmd_next.value    = 24'h000000;
              cmd_next.is_write = 1'b0;
              valid_next        = 1'b1;
            end
          end else begin
            asm_next.value = val_new;
            if (idx_reg == `LAST_VAL_IDX) begin
              idx_next          = 2'h0;
              cmd_next.op       = asm_reg.op;     // see (R6)
              cmd_next.value    = val_new;
              cmd_next.is_write = 1'b1;
              valid_next        = 1'b1;
              if (asm_reg.op == `CTRL_WR_OP &&
                  val_new[`STOP_BIT_POS]) begin
                // Stop write ends the fetch
                state_next = S_DONE;              // see (R9)
                start_next = 1'b0;
                cs_next    = 1'b1;                // see (R10)
                own_next   = 1'b0;                // see (R10)
                done_next  = 1'b1;                // see (R9)
              end
            end else begin
              idx_next = idx_reg + 2'h1;
            end
          end
        end
      end
      S_DONE: begin
        // Normal operation with the loaded registers
        state_next = S_DONE;
      end
      S_HOST: begin
        // No boot: the host owns the port
        state_next = S_HOST;
      end
      default: begin
        state_next = S_SETTLE;
      end
    endcase
    // Enables follow ownership, kept in a flop for the pins
    oe_n_next = !own_next;                        // see (R2)
  end

  // Register the loader
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg  <= S_SETTLE;
      settle_reg <= 2'h0;
      start_reg  <= 1'b0;
      tx_reg     <= 8'h00;
      idx_reg    <= 2'h0;
      asm_reg    <= '0;
      cmd_reg    <= '0;
      valid_reg  <= 1'b0;
      cs_reg     <= 1'b1;
      own_reg    <= 1'b0;
      done_reg   <= 1'b0;
      oe_n_reg   <= 1'b1;
    end else begin
      state_reg  <= state_next;
      settle_reg <= settle_next;
      start_reg  <= start_next;
      tx_reg     <= tx_next;
      idx_reg    <= idx_next;
      asm_reg    <= asm_next;
      cmd_reg    <= cmd_next;
      valid_reg  <= valid_next;
      cs_reg     <= cs_next;
      own_reg    <= own_next;
      done_reg   <= done_next;
      oe_n_reg   <= oe_n_next;
    end
  end

  // Pin drive: enables low only while the device owns the port
  always_comb begin
    link_o.cs_n      = cs_reg;                    // see (R3)
    link_o.cs_oe_n   = oe_n_reg;                  // see (R2)
    link_o.sclk      = sh_sclk;
    link_o.sclk_oe_n = oe_n_reg;
    link_o.sdo       = sh_sdo;
  end

  assign cmd       = cmd_reg;
  assign cmd_valid = valid_reg;
  assign boot_busy = own_reg;
  assign boot_done = done_reg;
  assign host_cs_n = cs_sync[1];
  assign host_sclk = sclk_sync[1];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_strap_boot: assert property ( // see (R1)
    state_reg == S_SETTLE && settle_reg == `STRAP_SETTLE && strap_sync[1]
    |=> state_reg == S_OPC && start_reg)
    else $error("strap high did not start boot");
  a_port_owned: assert property ( // see (R2)
    state_reg inside {S_OPC, S_ADR, S_FETCH}
    |-> !link_o.cs_oe_n && !link_o.sclk_oe_n)
    else $error("port not driven during boot");
  a_cs_low_boot: assert property ( // see (R3)
    state_reg inside {S_OPC, S_ADR, S_FETCH} |-> !link_o.cs_n)
    else $error("chip select high during boot");
  a_opcode_first: assert property ( // see (R4)
    start_reg && state_reg == S_OPC |-> tx_reg == `RD_OPCODE)
    else $error("first byte is not read opcode");
  a_byte_sampled: assert property ( // see (R5)
    sh_done && state_reg == S_FETCH && idx_reg == `LAST_VAL_IDX
    |=> cmd_reg.value[7:0] == $past(sh_rx))
    else $error("last value byte not taken");
  a_write_issue: assert property ( // see (R6)
    sh_done && state_reg == S_FETCH && idx_reg == `LAST_VAL_IDX
    |=> valid_reg && cmd_reg.is_write)
    else $error("write not issued after three bytes");
  a_single_cmd: assert property ( // see (R7)
    sh_done && state_reg == S_FETCH && idx_reg == 2'h0 &&
    sh_rx[7:6] != `WR_CLASS |=> valid_reg && !cmd_reg.is_write)
    else $error("single command not issued");
  a_valid_pulse: assert property ( // see (R8)
    valid_reg |=> !valid_reg [*8])
    else $error("command strobe too close");
  a_stop_ends: assert property ( // see (R9)
    valid_reg && cmd_reg.op == `CTRL_WR_OP &&
    cmd_reg.value[`STOP_BIT_POS] |-> state_reg == S_DONE)
    else $error("stop write did not end boot");
  a_port_free: assert property ( // see (R10)
    state_reg inside {S_DONE, S_HOST}
    |-> link_o.cs_oe_n && link_o.sclk_oe_n && link_o.cs_n)
    else $error("port still driven after boot");

  c_boot_done: cover property (state_reg == S_FETCH ##1 state_reg == S_DONE);
  c_single:    cover property (valid_reg && !cmd_reg.is_write);
  c_no_boot:   cover property (state_reg == S_HOST);

endmodule
`default_nettype wire

// >>> test/boot_script_mem.sv
// Model of the serial memory that holds the boot script.
// Assumes mode 0 framing: bits in on the clock rise, out after a fall.
`timescale 1ns/10ps
`default_nettype none

module boot_script_mem (
  input  wire logic        cs_n, // Select from the device, low active
  input  wire logic        sclk, // Clock made by the device
  input  wire logic        si,   // Data from the device
  input  wire logic        slow, // Late data edges when high
  output logic             so,   // Data towards the device
  output logic [15:0]      hdr   // Opcode and address as received
);
  logic [7:0]  rom [0:24]; // Script bytes
  logic [7:0]  b;          // Byte being sent
  int unsigned nbit;       // Clock rises in this frame
  int unsigned idx;        // Byte index being sent

  // Example script: writes, one single-byte command, stop write
  initial begin
    rom = '{8'h40, 8'h00, 8'h00, 8'h61, 8'h44, 8'h7f, 8'hc4, 8'ha9,
            8'h48, 8'hff, 8'hb2, 8'h53, 8'h4c, 8'h00, 8'h7d, 8'h00,
            8'h74, 8'h00, 8'h00, 8'h04, 8'he8, 8'h78, 8'h00, 8'h01,
            8'h00};
    so   = 1'b0;
    hdr  = 16'h0000;
    nbit = 0;
  end

  // New frame starts counting afresh
  always @(negedge cs_n) begin
    nbit = 0;
  end

  // Released line shows no stale value
  always @(posedge cs_n) begin
    so <= #1 ~so;
  end

  // Header bits taken on the rise
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (nbit < 16)
        hdr = {hdr[14:0], si};
      nbit = nbit + 1;
    end
  end

  // Stored bits only after the read opcode and address, msb first
  always @(negedge sclk) begin
    if (!cs_n && nbit >= 16) begin
      idx = hdr[7:0] + (nbit - 16) / 8;
      b   = (idx < 25) ? rom[idx] : 8'h00;
      if (hdr[15:8] != 8'h03 || idx >= 25)
        so <= #(slow ? 30 : 2) ~so;
      else
        so <= #(slow ? 30 : 2) b[7 - ((nbit - 16) % 8)];
    end
  end
endmodule

`default_nettype wire

// >>> test/serial_eeprom_autoboot_loader_tb.sv
// Bench for the boot loader: strap choice, script fetch, release.
// Assumes the package, the loader and the memory model are compiled.
`timescale 1ns/10ps
`default_nettype none

module serial_eeprom_autoboot_loader_tb;
  import boot_pkg::*;
  logic        clk = 1'b0;          // Core clock
  logic        rstn, boot_strap;    // Reset and strap
  logic        slow, hrun;          // Memory speed, host clock run
  logic        hcs, hsck;           // Host pin drive
  wire logic   cs_w, sck_w, sdi_w;  // Pin levels
  link_out_t   lo;                  // Device pin drive
  boot_cmd_t   cmd;                 // Executed command
  logic        cmd_valid, busy;     // Command strobe, fetch running
  logic        done, h_cs, h_sck;   // Ended, forwarded host pins
  logic [15:0] hdr;                 // Header seen by the memory
  int          n_fail = 0;          // Mismatches
  int          samples_checked = 0; // Comparisons
  boot_cmd_t   exp_cmds [7];        // Script as commands

  always #4 clk = ~clk;
  // Host clock, unrelated phase
  initial begin
    #3;
    forever #40 if (hrun) hsck = ~hsck;
  end
  // Undriven select floats high through the host side
  assign cs_w  = lo.cs_oe_n ? hcs : lo.cs_n;
  assign sck_w = lo.sclk_oe_n ? hsck : lo.sclk;

  serial_eeprom_autoboot_loader dut (
    .clk(clk), .rstn(rstn), .boot_strap(boot_strap), .cs_n_in(cs_w),
    .sclk_in(sck_w), .sdi(sdi_w), .link_o(lo), .cmd(cmd),
    .cmd_valid(cmd_valid), .boot_busy(busy), .boot_done(done),
    .host_cs_n(h_cs), .host_sclk(h_sck));

  boot_script_mem mem (
    .cs_n(cs_w), .sclk(sck_w), .si(lo.sdo), .slow(slow), .so(sdi_w),
    .hdr(hdr));

  task automatic tally_and_finish();
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_cmd(input boot_cmd_t g, input boot_cmd_t e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Reset for 12 cycles with the strap set beforehand
  task automatic reset_with(input logic s);
    @(negedge clk);
    rstn = 1'b0;
    boot_strap = s;
    cyc(12);
    rstn = 1'b1;
  endtask

  // Bounded wait for the command strobe
  task automatic wait_cmd();
    int k;
    for (k = 0; k < 2000; k++) begin
      @(negedge clk);
      if (cmd_valid === 1'b1)
        return;
    end
    n_fail++;
    tally_and_finish();
  endtask

  // Strap low: port left to the host, pins forwarded
  task automatic run_noboot();
    int i;
    reset_with(1'b0);
    hrun = 1'b1;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      chk_bit(lo.cs_oe_n & lo.sclk_oe_n & ~busy & ~cmd_valid,
              1'b1);
    end
    hrun = 1'b0;
    for (i = 0; i < 2; i++) begin
      hsck = i[0];
      hcs = ~i[0];
      cyc(4);
      chk_bit(h_sck, i[0]);
      chk_bit(h_cs, ~i[0]);
    end
    hsck = 1'b0;
    hcs = 1'b1;
  endtask

  // Full boot with prompt or late memory data
  task automatic run_boot(input logic sl);
    int i;
    slow = sl;
    reset_with(1'b1);
    cyc(8);
    chk_bit(busy, 1'b1);
    chk_bit(lo.cs_oe_n | lo.sclk_oe_n, 1'b0);
    chk_bit(lo.cs_n, 1'b0);
    boot_strap = 1'b0; // Late strap change must be ignored
    for (i = 0; i < 7; i++) begin
      wait_cmd();
      if (i == 0)
        chk_word(hdr, 16'h0300);
      if (exp_cmds[i].is_write)
        chk_cmd(cmd, exp_cmds[i]);
      else
        chk_word({7'h0, cmd.is_write, cmd.op},
                 {8'h0, exp_cmds[i].op});
      chk_bit(done, i == 6);
      chk_bit(lo.cs_oe_n & lo.sclk_oe_n & ~busy, i == 6);
      cyc(1);
      chk_bit(cmd_valid, 1'b0);
    end
    for (i = 0; i < 200; i++) begin
      @(negedge clk);
      if (cmd_valid !== 1'b0)
        chk_bit(cmd_valid, 1'b0);
    end
    hcs = 1'b0;
    cyc(4);
    chk_bit(h_cs, 1'b0);
    hcs = 1'b1;
  endtask

  initial begin
    rstn = 1'b0;
    boot_strap = 1'b0;
    slow = 1'b0;
    hrun = 1'b0;
    hcs = 1'b1;
    hsck = 1'b0;
    exp_cmds = '{'{1'b1, 8'h40, 24'h000061}, '{1'b1, 8'h44, 24'h7fc4a9},
                 '{1'b1, 8'h48, 24'hffb253}, '{1'b1, 8'h4c, 24'h007d00},
                 '{1'b1, 8'h74, 24'h000004}, '{1'b0, 8'he8, 24'h000000},
                 '{1'b1, 8'h78, 24'h000100}};
    run_noboot();
    run_boot(1'b0);
    run_boot(1'b1);
    tally_and_finish();
  end
endmodule

`default_nettype wire
